// >>> src/pdcc_cfg.svh
// Offsets, field positions and reset values for the device capability/control block.
// Assumes byte addressing on a 32-bit register bus.
`ifndef PDCC_CFG_SVH
`define PDCC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDCC_OFS_DEV_CAP      8'hc4
`define PDCC_OFS_DEV_CTL      8'hc8

// ----------------------------------------
// Capabilities word fields
// ----------------------------------------
`define PDCC_CAP_MPS_LSB      0
`define PDCC_CAP_RBE_BIT      15
`define PDCC_CAP_SPLV_LSB     18
`define PDCC_CAP_SPLS_LSB     26

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define PDCC_CTL_CORR_BIT     0
`define PDCC_CTL_NONFATAL_BIT 1
`define PDCC_CTL_FATAL_BIT    2
`define PDCC_CTL_UR_BIT       3
`define PDCC_CTL_MPS_LSB      5
`define PDCC_CTL_AUX_BIT      10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDCC_RST_CAP_MPS_SMALL 3'h1
`define PDCC_RST_CAP_MPS_LARGE 3'h2
`define PDCC_RST_RBE           1'h1
`define PDCC_RST_SPL_VALUE     8'h00
`define PDCC_RST_SPL_SCALE     2'h0
`define PDCC_RST_ERR_EN        4'h0
`define PDCC_RST_MPS           3'h0
`define PDCC_RST_AUX           1'h0

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define PDCC_RESP_OKAY        2'h0
`define PDCC_RESP_SLVERR      2'h2

`endif

// >>> src/pdcc_pkg.sv
// Types shared by the device capability/control block.
// Assumes nothing of its surroundings.
package pdcc_pkg;

	// Control outputs to the port logic
	typedef struct packed {
		logic       aux_pm_en;
		logic [2:0] mps;
		logic       ur_en;
		logic       fatal_en;
		logic       nonfatal_en;
		logic       corr_en;
	} pdcc_ctrl_type;

	// Hardware-initialized defaults from eeprom or management port
	typedef struct packed {
		logic       valid;
		logic [2:0] cap_mps;
		logic       role_err;
	} pdcc_load_type;

	// Received slot power limit message
	typedef struct packed {
		logic       valid;
		logic [7:0] value;
		logic [1:0] scale;
	} pdcc_spl_type;

endpackage

// >>> src/pdcc_axil_slave.sv
// AXI4-Lite slave front end for the capability/control registers.
// Assumes the parent decodes addresses and applies the one-cycle write strobe.
`timescale 1ns/1ps
`include "pdcc_cfg.svh"

module pdcc_axil_slave import pdcc_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              ce,
	// Write channels
	input  wire logic [ADDR_W-1:0] s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	// Read channels
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	// Register side
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_hit,
	input  wire logic              wr_hit,
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb
);

	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [ADDR_W-1:0] addr_next;
	logic [31:0] data_next;
	logic [3:0] strb_next;
	logic awready_next, wready_next, bvalid_next, wr_en_next;
	logic [1:0] bresp_next;
	logic arready_next, rvalid_next;
	logic [31:0] rdata_next;
	logic [1:0] rresp_next;

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next  = w_full_reg;
		addr_next    = wr_addr;
		data_next    = wr_data;
		strb_next    = wr_strb;
		bvalid_next  = s_bvalid;
		bresp_next   = s_bresp;
		wr_en_next   = 1'b0;
		if (s_awvalid && s_awready) begin
			aw_full_next = 1'b1;
			addr_next    = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			w_full_next = 1'b1;
			data_next   = s_wdata;
			strb_next   = s_wstrb;
		end
		if (s_bvalid && s_bready)
			bvalid_next = 1'b0;
		if (aw_full_reg && w_full_reg && !s_bvalid) begin
			aw_full_next = 1'b0;
			w_full_next  = 1'b0;
			bvalid_next  = 1'b1;
			wr_en_next   = wr_hit;
			bresp_next   = wr_hit ? `PDCC_RESP_OKAY : `PDCC_RESP_SLVERR;
		end
		awready_next = !aw_full_next;
		wready_next  = !w_full_next;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			wr_addr     <= '0;
			wr_data     <= 32'h0;
			wr_strb     <= 4'h0;
			s_awready   <= 1'b0;
			s_wready    <= 1'b0;
			s_bvalid    <= 1'b0;
			s_bresp     <= `PDCC_RESP_OKAY;
			wr_en       <= 1'b0;
		end else if (ce) begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			wr_addr     <= addr_next;
			wr_data     <= data_next;
			wr_strb     <= strb_next;
			s_awready   <= awready_next;
			s_wready    <= wready_next;
			s_bvalid    <= bvalid_next;
			s_bresp     <= bresp_next;
			wr_en       <= wr_en_next;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rvalid_next = s_rvalid;
		rdata_next  = s_rdata;
		rresp_next  = s_rresp;
		if (s_rvalid && s_rready)
			rvalid_next = 1'b0;
		if (s_arvalid && s_arready) begin
			rvalid_next = 1'b1;
			rdata_next  = rd_hit ? rd_data : 32'h0;
			rresp_next  = rd_hit ? `PDCC_RESP_OKAY : `PDCC_RESP_SLVERR;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0;
			s_rresp   <= `PDCC_RESP_OKAY;
		end else if (ce) begin
			s_arready <= arready_next;
			s_rvalid  <= rvalid_next;
			s_rdata   <= rdata_next;
			s_rresp   <= rresp_next;
		end
	end

endmodule // pdcc_axil_slave

// >>> src/pdcc_regs.sv
// Device capabilities word and lower half of the device control word of one switch port.
// Assumes synchronous inputs on clk, software access over AXI4-Lite, and a separate power-on reset.
//
// Notes on behaviour
// - Payload capability resets 001b, or 010b with strap
// - Strap or autoload may override payload capability
// - Phantom function capability reads 00b
// - Extended tag capability reads zero
// - Low-power latency fields read-only, reset 000b
// - Role-based error bit resets one, loadable
// - Upstream slot power value captured from message
// - Upstream slot power scale captured likewise
// - Control bits 0-2 error reporting enables
// - Control bit 3 unsupported request enable
// - Relaxed ordering permission reads zero
// - Payload size writable, clamped to capability
// - Extended tag, phantom enables read zero
// - Aux power enable is sticky read-write
// - No-snoop permission reads zero
// - Read request size hardwired 000b
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pdcc_cfg.svh"

module pdcc_regs import pdcc_pkg::*; #(
	parameter int ADDR_W   = 8,
	parameter bit UPSTREAM = 1'b1
) (
	// Clock, resets, enable
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              por_reset,
	input  wire logic              ce,
	// Straps and hardware-initialized loads
	input  wire logic              large_payload_strap,
	input  wire pdcc_load_type     hw_load,
	input  wire pdcc_spl_type      spl_msg,
	// Control outputs
	output pdcc_ctrl_type          ctrl,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	input  wire logic [ADDR_W-1:0] s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [2:0] clamp_mps(input logic [2:0] req, input logic [2:0] cap);
		clamp_mps = (req > cap) ? cap : req;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		is_mapped = (addr == ADDR_W'(`PDCC_OFS_DEV_CAP)) || (addr == ADDR_W'(`PDCC_OFS_DEV_CTL));
	endfunction

	logic [2:0] cap_mps_reg, cap_mps_next;
	logic       rbe_reg, rbe_next;
	logic [7:0] spl_value_reg, spl_value_next;
	logic [1:0] spl_scale_reg, spl_scale_next;
	logic [3:0] err_en_reg, err_en_next;
	logic [2:0] mps_reg, mps_next;
	logic       aux_reg, aux_next;
	logic [31:0] cap_word, ctl_word, rd_data;
	logic        rd_hit, wr_hit, wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        ctl_wr_lo, ctl_wr_hi;

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	pdcc_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.rd_data   (rd_data),
		.rd_hit    (rd_hit),
		.wr_hit    (wr_hit),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.wr_strb   (wr_strb)
	);

	assign rd_hit    = is_mapped(s_araddr);
	assign wr_hit    = is_mapped(wr_addr);
	assign ctl_wr_lo = wr_en && (wr_addr == ADDR_W'(`PDCC_OFS_DEV_CTL)) && wr_strb[0];
	assign ctl_wr_hi = wr_en && (wr_addr == ADDR_W'(`PDCC_OFS_DEV_CTL)) && wr_strb[1];

	// ----------------------------------------
	// Read word assembly
	// ----------------------------------------
	always_comb begin
		cap_word = 32'h0;
		cap_word[`PDCC_CAP_MPS_LSB +: 3]  = cap_mps_reg;
		cap_word[`PDCC_CAP_RBE_BIT]       = rbe_reg;
		cap_word[`PDCC_CAP_SPLV_LSB +: 8] = spl_value_reg;
		cap_word[`PDCC_CAP_SPLS_LSB +: 2] = spl_scale_reg;
		ctl_word = 32'h0;
		ctl_word[`PDCC_CTL_CORR_BIT]      = err_en_reg[0];
		ctl_word[`PDCC_CTL_NONFATAL_BIT]  = err_en_reg[1];
		ctl_word[`PDCC_CTL_FATAL_BIT]     = err_en_reg[2];
		ctl_word[`PDCC_CTL_UR_BIT]        = err_en_reg[3];
		ctl_word[`PDCC_CTL_MPS_LSB +: 3]  = mps_reg;
		ctl_word[`PDCC_CTL_AUX_BIT]       = aux_reg;
		if (s_araddr == ADDR_W'(`PDCC_OFS_DEV_CAP))
			rd_data = cap_word;
		else if (s_araddr == ADDR_W'(`PDCC_OFS_DEV_CTL))
			rd_data = ctl_word;
		else
			rd_data = 32'h0;
	end

	// ----------------------------------------
	// Capabilities word
	// ----------------------------------------
	always_comb begin
		cap_mps_next   = cap_mps_reg;
		rbe_next       = rbe_reg;
		spl_value_next = spl_value_reg;
		spl_scale_next = spl_scale_reg;
		if (hw_load.valid) begin
			cap_mps_next = hw_load.cap_mps;
			rbe_next     = hw_load.role_err;
		end
		if (UPSTREAM && spl_msg.valid) begin
			spl_value_next = spl_msg.value;
			spl_scale_next = spl_msg.scale;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cap_mps_reg   <= large_payload_strap ? `PDCC_RST_CAP_MPS_LARGE : `PDCC_RST_CAP_MPS_SMALL;
			rbe_reg       <= `PDCC_RST_RBE;
			spl_value_reg <= `PDCC_RST_SPL_VALUE;
			spl_scale_reg <= `PDCC_RST_SPL_SCALE;
		end else if (ce) begin
			cap_mps_reg   <= cap_mps_next;
			rbe_reg       <= rbe_next;
			spl_value_reg <= spl_value_next;
			spl_scale_reg <= spl_scale_next;
		end
	end

	// ----------------------------------------
	// Control word, port reset domain
	// ----------------------------------------
	always_comb begin
		err_en_next = err_en_reg;
		mps_next    = mps_reg;
		if (ctl_wr_lo) begin
			err_en_next = wr_data[`PDCC_CTL_UR_BIT:`PDCC_CTL_CORR_BIT];
			mps_next    = clamp_mps(wr_data[`PDCC_CTL_MPS_LSB +: 3], cap_mps_reg);
		end else begin
			// Keep the setting legal if the capability is reloaded lower
			mps_next = clamp_mps(mps_reg, cap_mps_reg);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			err_en_reg <= `PDCC_RST_ERR_EN;
			mps_reg    <= `PDCC_RST_MPS;
		end else if (ce) begin
			err_en_reg <= err_en_next;
			mps_reg    <= mps_next;
		end
	end

	// ----------------------------------------
	// Sticky aux power enable, power-on reset only
	// ----------------------------------------
	always_comb begin
		aux_next = aux_reg;
		if (ctl_wr_hi)
			aux_next = wr_data[`PDCC_CTL_AUX_BIT];
	end

	always_ff @(posedge clk) begin
		if (por_reset)
			aux_reg <= `PDCC_RST_AUX;
		else if (ce && !reset)
			aux_reg <= aux_next;
	end

	assign ctrl = '{aux_pm_en: aux_reg, mps: mps_reg, ur_en: err_en_reg[3], fatal_en: err_en_reg[2],
			nonfatal_en: err_en_reg[1], corr_en: err_en_reg[0]};

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_cap_mps_reset;
		@(posedge clk) reset |=> (cap_mps_reg == ($past(large_payload_strap) ? 3'h2 : 3'h1));
	endproperty
	a_cap_mps_reset: assert property (p_cap_mps_reset) else $error("payload capability reset wrong");

	property p_cap_mps_load;
		@(posedge clk) disable iff (reset) ce && hw_load.valid |=> cap_mps_reg == $past(hw_load.cap_mps);
	endproperty
	a_cap_mps_load: assert property (p_cap_mps_load) else $error("payload capability load lost");

	property p_cap_fixed_zero;
		@(posedge clk) disable iff (reset) s_arvalid && s_arready && s_araddr == ADDR_W'(`PDCC_OFS_DEV_CAP)
			|=> s_rvalid && s_rdata[14:3] == 12'h000 && s_rdata[17:16] == 2'h0 && s_rdata[31:28] == 4'h0;
	endproperty
	a_cap_fixed_zero: assert property (p_cap_fixed_zero) else $error("capability fixed bits nonzero");

	property p_rbe_reset;
		@(posedge clk) reset ##1 !reset && !hw_load.valid |-> rbe_reg;
	endproperty
	a_rbe_reset: assert property (p_rbe_reset) else $error("role-based error bit not set after reset");

	property p_spl_capture;
		@(posedge clk) disable iff (reset) ce && spl_msg.valid |=>
			spl_value_reg == (UPSTREAM ? $past(spl_msg.value) : 8'h00)
			&& spl_scale_reg == (UPSTREAM ? $past(spl_msg.scale) : 2'h0);
	endproperty
	a_spl_capture: assert property (p_spl_capture) else $error("slot power limit not captured");

	property p_err_en_write;
		@(posedge clk) disable iff (reset) ce && ctl_wr_lo |=> ctrl.corr_en == $past(wr_data[0])
			&& ctrl.nonfatal_en == $past(wr_data[1]) && ctrl.fatal_en == $past(wr_data[2])
			&& ctrl.ur_en == $past(wr_data[3]);
	endproperty
	a_err_en_write: assert property (p_err_en_write) else $error("error enables not written");

	property p_ctl_fixed_zero;
		@(posedge clk) disable iff (reset) s_arvalid && s_arready && s_araddr == ADDR_W'(`PDCC_OFS_DEV_CTL)
			|=> s_rdata[4] == 1'b0 && s_rdata[9:8] == 2'h0 && s_rdata[15:11] == 5'h00 && s_rdata[31:16] == 16'h0;
	endproperty
	a_ctl_fixed_zero: assert property (p_ctl_fixed_zero) else $error("control fixed bits nonzero");

	property p_mps_clamp;
		@(posedge clk) disable iff (reset) ce && ctl_wr_lo && !hw_load.valid |=>
			mps_reg == (($past(wr_data[7:5]) > $past(cap_mps_reg)) ? $past(cap_mps_reg) : $past(wr_data[7:5]));
	endproperty
	a_mps_clamp: assert property (p_mps_clamp) else $error("payload size not clamped");

	property p_aux_sticky;
		@(posedge clk) reset && !por_reset |=> aux_reg == $past(aux_reg);
	endproperty
	a_aux_sticky: assert property (p_aux_sticky) else $error("aux enable lost on port reset");

	property p_aux_por;
		@(posedge clk) por_reset |=> !aux_reg;
	endproperty
	a_aux_por: assert property (p_aux_por) else $error("aux enable not cleared by power-on reset");

	property p_unmapped_read;
		@(posedge clk) disable iff (reset) s_arvalid && s_arready && !is_mapped(s_araddr)
			|=> s_rresp == 2'h2 && s_rdata == 32'h0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answered wrongly");

	property p_ctrl_reset;
		@(posedge clk) reset |=> ctrl.mps == 3'h0 && !ctrl.ur_en && !ctrl.fatal_en && !ctrl.nonfatal_en && !ctrl.corr_en;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control enables not cleared by reset");

	property p_aux_write;
		@(posedge clk) ce && ctl_wr_hi && !reset && !por_reset |=> aux_reg == $past(wr_data[`PDCC_CTL_AUX_BIT]);
	endproperty
	a_aux_write: assert property (p_aux_write) else $error("aux enable not written");

	property p_mps_bounded;
		@(posedge clk) disable iff (reset) ce && !hw_load.valid |=> mps_reg <= $past(cap_mps_reg);
	endproperty
	a_mps_bounded: assert property (p_mps_bounded) else $error("payload size above capability");

	property p_ce_freeze;
		@(posedge clk) disable iff (reset) !ce |=> $stable(cap_mps_reg) && $stable(rbe_reg) && $stable(spl_value_reg)
			&& $stable(spl_scale_reg) && $stable(err_en_reg) && $stable(mps_reg);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

endmodule // pdcc_regs

// >>> testbench/pdcc_regs_test.sv
// Self-checking bench for the device capability/control register block.
// Assumes the block answers on AXI4-Lite and the bench drives every input itself.
`timescale 1ns/1ps
`include "pdcc_cfg.svh"

module pdcc_regs_test import pdcc_pkg::*;;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic          clk = 1'b0;
	logic          reset = 1'b1;
	logic          por_reset = 1'b1;
	logic          ce = 1'b1;
	logic          large_payload_strap = 1'b0;
	pdcc_load_type hw_load = '0;
	pdcc_spl_type  spl_msg = '0;
	pdcc_ctrl_type ctrl;
	logic [7:0]    s_awaddr = 8'h00, s_araddr = 8'h00;
	logic [31:0]   s_wdata = 32'h0, s_rdata;
	logic [3:0]    s_wstrb = 4'h0;
	logic          s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic          s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]    s_bresp, s_rresp;
	logic [33:0]   exp_r[$];
	logic [1:0]    exp_b[$];
	int            fail_count = 0;
	int            num_checks = 0;
	logic [2:0]    m_cap, m_mps;
	logic [3:0]    m_en;
	logic [7:0]    m_val;
	logic [1:0]    m_scl;
	logic          m_rbe, m_aux;
	logic [31:0]   d;

	always #4 clk = ~clk;

	pdcc_regs #(.ADDR_W(8), .UPSTREAM(1'b1)) dut (
		.clk(clk), .reset(reset), .por_reset(por_reset), .ce(ce),
		.large_payload_strap(large_payload_strap), .hw_load(hw_load), .spl_msg(spl_msg), .ctrl(ctrl),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready)
	);

	// ----------------------------------------
	// Checking and expected words
	// ----------------------------------------
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] cap_word();
		return {4'h0, m_scl, m_val, 2'h0, m_rbe, 12'h000, m_cap};
	endfunction

	function automatic logic [31:0] ctl_word();
		return {16'h0000, 5'h00, m_aux, 2'h0, m_mps, 1'b0, m_en};
	endfunction

	function automatic logic [2:0] clamp(input logic [2:0] v);
		return (v > m_cap) ? m_cap : v;
	endfunction

	// Result watcher: oldest note against each response
	always @(posedge clk) begin
		if (s_rvalid === 1'b1 && s_rready) check({s_rresp, s_rdata}, exp_r.size() ? exp_r.pop_front() : 34'h0_dead_beef);
		if (s_bvalid === 1'b1 && s_bready) check({s_bresp, 32'h0}, {exp_b.size() ? exp_b.pop_front() : 2'h3, 32'h0});
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic do_reset(input logic por, input logic strap);
		@(posedge clk);
		reset <= 1'b1;
		por_reset <= por;
		large_payload_strap <= strap;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		por_reset <= 1'b0;
		repeat (2) @(posedge clk);
		m_cap = strap ? `PDCC_RST_CAP_MPS_LARGE : `PDCC_RST_CAP_MPS_SMALL;
		m_rbe = `PDCC_RST_RBE;
		m_val = `PDCC_RST_SPL_VALUE;
		m_scl = `PDCC_RST_SPL_SCALE;
		m_en = `PDCC_RST_ERR_EN;
		m_mps = `PDCC_RST_MPS;
		if (por) m_aux = `PDCC_RST_AUX;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st, input logic [1:0] resp);
		exp_b.push_back(resp);
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= wd;
		s_wstrb <= st;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
		do @(posedge clk); while (!s_bvalid);
		s_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] rd_exp, input logic [1:0] resp);
		exp_r.push_back({resp, rd_exp});
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge clk); while (!s_arready);
		s_arvalid <= 1'b0;
		do @(posedge clk); while (!s_rvalid);
		s_rready <= 1'b0;
	endtask

	task automatic chk_ctrl();
		@(posedge clk);
		#1;
		check({26'h0, ctrl}, {26'h0, m_aux, m_mps, m_en});
	endtask

	task automatic pulse_load(input logic [2:0] c, input logic r);
		@(posedge clk);
		hw_load <= {1'b1, c, r};
		@(posedge clk);
		hw_load <= '0;
		m_cap = c;
		m_rbe = r;
		m_mps = clamp(m_mps);
	endtask

	task automatic pulse_spl(input logic [7:0] v, input logic [1:0] s, input logic en);
		@(posedge clk);
		ce <= en;
		spl_msg <= {1'b1, v, s};
		@(posedge clk);
		spl_msg <= '0;
		ce <= 1'b1;
		if (en) begin
			m_val = v;
			m_scl = s;
		end
	endtask

	task automatic results();
		if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(24581));
		do_reset(1'b1, 1'b0);
		rd(`PDCC_OFS_DEV_CAP, cap_word(), `PDCC_RESP_OKAY);
		rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
		wr(`PDCC_OFS_DEV_CAP, 32'hffff_ffff, 4'hf, `PDCC_RESP_OKAY);
		rd(`PDCC_OFS_DEV_CAP, cap_word(), `PDCC_RESP_OKAY);
		wr(`PDCC_OFS_DEV_CTL, 32'hffff_ffff, 4'hf, `PDCC_RESP_OKAY);
		m_en = 4'hf;
		m_mps = clamp(3'h7);
		m_aux = 1'b1;
		rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
		chk_ctrl();
		wr(`PDCC_OFS_DEV_CTL, 32'h0000_0000, 4'h2, `PDCC_RESP_OKAY);
		m_aux = 1'b0;
		rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			wr(`PDCC_OFS_DEV_CTL, d, 4'hf, `PDCC_RESP_OKAY);
			m_en = d[3:0];
			m_mps = clamp(d[7:5]);
			m_aux = d[10];
			rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
			chk_ctrl();
		end
		pulse_load(3'h5, 1'b0);
		rd(`PDCC_OFS_DEV_CAP, cap_word(), `PDCC_RESP_OKAY);
		wr(`PDCC_OFS_DEV_CTL, 32'h0000_00e0, 4'h1, `PDCC_RESP_OKAY);
		m_en = 4'h0;
		m_mps = clamp(3'h7);
		rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
		pulse_load(3'h1, 1'b1);
		rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
		rd(`PDCC_OFS_DEV_CAP, cap_word(), `PDCC_RESP_OKAY);
		d = $urandom;
		pulse_spl(d[7:0], d[9:8], 1'b1);
		rd(`PDCC_OFS_DEV_CAP, cap_word(), `PDCC_RESP_OKAY);
		pulse_spl(~d[7:0], ~d[9:8], 1'b0);
		rd(`PDCC_OFS_DEV_CAP, cap_word(), `PDCC_RESP_OKAY);
		wr(8'h40, 32'hffff_ffff, 4'hf, `PDCC_RESP_SLVERR);
		rd(8'h40, 32'h0, `PDCC_RESP_SLVERR);
		wr(`PDCC_OFS_DEV_CTL, 32'h0000_0400, 4'h3, `PDCC_RESP_OKAY);
		m_en = 4'h0;
		m_mps = 3'h0;
		m_aux = 1'b1;
		do_reset(1'b0, 1'b1);
		rd(`PDCC_OFS_DEV_CAP, cap_word(), `PDCC_RESP_OKAY);
		rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
		chk_ctrl();
		do_reset(1'b1, 1'b1);
		rd(`PDCC_OFS_DEV_CTL, ctl_word(), `PDCC_RESP_OKAY);
		repeat (2) @(posedge clk);
		results();
	end

	// Watchdog against a stuck handshake
	initial begin
		#100000;
		fail_count++;
		results();
	end

endmodule // pdcc_regs_test
